// *** rtl/cpu_address_map_decoder.sv ***
// Top of the CPU address map decoder: translation, decode and routing.
// Assumes requester holds the request until ready and targets answer in one cycle.
// Selects, offsets and strobes are registered; only req_ready is combinational.
// The window base is a static level set at initialization, on the system clock.
`timescale 1ns/100ps
module cpu_address_map_decoder
  import addr_map_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [PHYS_AW-1:0] peripheral_window_base_select,
  input wire logic prog_mode,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_fetch,
  input wire logic req_write,
  input wire logic [1:0] req_size,
  input wire logic req_byte_reg,
  input wire logic [CPU_AW-1:0] req_base,
  input wire logic [CPU_AW-1:0] req_disp,
  input wire logic [15:0] req_wdata,
  input wire logic branch_load,
  input wire logic [CPU_AW-1:0] branch_target,
  output logic [CPU_AW-1:0] pc_ff,
  output logic boot_load_ff,
  output logic [5:0] sel_ff,
  output logic [PHYS_AW-1:0] phys_addr_ff,
  output logic [RAM_OFS_W-1:0] ram_addr_ff,
  output logic [PERI_OFS_W-1:0] peri_addr_ff,
  output logic [15:0] peri_wdata_ff,
  output logic peri_write_ff,
  output logic fetch_fault_ff,
  input wire logic [15:0] peri_rdata,
  output logic [15:0] rdata_ff
);
  // ----------------------------------------------------------------------
  // Address arithmetic
  // ----------------------------------------------------------------------
  logic [CPU_AW-1:0] data_sum;
  logic [PROG_AW-1:0] prog_sum;
  logic [PHYS_AW-1:0] nxt_phys;
  logic [CPU_AW-1:0] nxt_pc;
  logic [PPW_BASE_W-1:0] base_lo;
  logic is_byte_reg_half_ff;
  region_if rif();

  // Sums wrap at their own width
  always_comb begin
    data_sum = req_base + req_disp;
    prog_sum = req_base[PROG_AW-1:0] + req_disp[PROG_AW-1:0];
    if (req_fetch) begin
      nxt_phys = {{(PHYS_AW-PROG_AW){1'b0}}, prog_sum};
    end else begin
      nxt_phys = data_sum[PHYS_AW-1:0];
    end
    base_lo = '0;
  end

  // Window base aligned to 16 KB
  assign rif.phys = nxt_phys;
  assign rif.ppw_base = {peripheral_window_base_select[PHYS_AW-1:PPW_BASE_W], base_lo};
  assign rif.fetch = req_fetch;

  // Region classifier works on the translated physical address
  region_classify u_classify (
    .rif(rif)
  );

  // ----------------------------------------------------------------------
  // Request acceptance
  // ----------------------------------------------------------------------
  // Decode answers in the same cycle, so requests are never stalled
  assign req_ready = 1'b1;

  // A request counts only on an edge where both sides agree
  logic req_take;
  assign req_take = req_valid && req_ready;

  // ----------------------------------------------------------------------
  // Next values for the peripheral side
  // ----------------------------------------------------------------------
  logic [PERI_OFS_W-1:0] nxt_peri_ofs;
  logic [15:0] nxt_peri_wdata;
  logic nxt_byte_half;

  // Word registers ignore the two lowest offset bits
  always_comb begin
    nxt_peri_ofs = rif.peri_ofs;
    if (req_size == SZ_WORD) begin
      nxt_peri_ofs = {rif.peri_ofs[PERI_OFS_W-1:WORD_ALIGN_W], {WORD_ALIGN_W{1'b0}}};
    end
  end

  // Half-word write into a byte register keeps only the low lane;
  // the upper lane is driven to zero so no stale data reaches the bus
  always_comb begin
    nxt_byte_half = req_byte_reg && (req_size == SZ_HALF);
    nxt_peri_wdata = req_wdata;
    if (nxt_byte_half) begin
      nxt_peri_wdata = {{($bits(req_wdata)-BYTE_LANE_W){1'b0}}, req_wdata[BYTE_LANE_W-1:0]};
    end
  end

  // ----------------------------------------------------------------------
  // Registered decode outcome
  // ----------------------------------------------------------------------
  // Target select pulses for one cycle per accepted request
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sel_ff <= TGT_NONE;
    end else if (req_take) begin
      sel_ff <= rif.target;
    end else begin
      sel_ff <= TGT_NONE;
    end
  end

  // Physical address of the last accepted request
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      phys_addr_ff <= '0;
    end else if (req_take) begin
      phys_addr_ff <= nxt_phys;
    end
  end

  // RAM cell offset, shared by the primary range and its mirror
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ram_addr_ff <= '0;
    end else if (req_take && rif.is_ram) begin
      ram_addr_ff <= rif.ram_ofs;
    end
  end

  // Peripheral offset, identical for the fixed area and the window alias
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      peri_addr_ff <= '0;
    end else if (req_take) begin
      peri_addr_ff <= nxt_peri_ofs;
    end
  end

  // Fetch into any peripheral region is flagged, never forwarded
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      fetch_fault_ff <= 1'b0;
    end else begin
      fetch_fault_ff <= req_take && (rif.target == TGT_FAULT);
    end
  end

  // ----------------------------------------------------------------------
  // Peripheral bus data path
  // ----------------------------------------------------------------------
  // Write data captured on every accepted write
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      peri_wdata_ff <= '0;
    end else if (req_take && req_write) begin
      peri_wdata_ff <= nxt_peri_wdata;
    end
  end

  // Write strobe only for data writes that land on the peripheral bus
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      peri_write_ff <= 1'b0;
    end else begin
      peri_write_ff <= req_take && req_write && rif.is_peri && !req_fetch;
    end
  end

  // Marks that the answer now on the bus belongs to a half-word access to a byte register;
  // idle cycles clear it so a stale size never masks later read data
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      is_byte_reg_half_ff <= 1'b0;
    end else begin
      is_byte_reg_half_ff <= req_take && nxt_byte_half;
    end
  end

  // Read data return, upper byte of byte register forced
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rdata_ff <= '0;
    end else if (is_byte_reg_half_ff) begin
      rdata_ff <= peri_rdata | BYTE_REG_UPPER;
    end else begin
      rdata_ff <= peri_rdata;
    end
  end

  // ----------------------------------------------------------------------
  // Program counter
  // ----------------------------------------------------------------------
  // Branch targets are cut to the program space before they are loaded
  always_comb begin
    nxt_pc = pc_ff;
    if (branch_load) begin
      nxt_pc = {{(CPU_AW-PROG_AW){1'b0}}, branch_target[PROG_AW-1:0]};
    end
  end

  // Execution restarts at the reset vector after every reset
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pc_ff <= {{(CPU_AW-PHYS_AW){1'b0}}, RESET_VECTOR};
    end else begin
      pc_ff <= nxt_pc;
    end
  end

  // Boot loader flag follows prog_mode on every clock after reset release
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      boot_load_ff <= 1'b0;
    end else begin
      boot_load_ff <= prog_mode;
    end
  end
endmodule

// *** pkg/addr_map_pkg.sv ***
// Constants, types and region layout for the CPU address map decoder.
// Assumes a single 125 MHz system clock domain and a synchronous reset.
package addr_map_pkg;

  // ----------------------------------------------------------------------
  // Address widths
  // ----------------------------------------------------------------------
  localparam int CPU_AW = 32;
  localparam int PHYS_AW = 28;
  localparam int PROG_AW = 26;
  localparam int PPW_BASE_W = 14; // Window base granularity bits (16 KB)

  // ----------------------------------------------------------------------
  // Region bounds on the physical address
  // ----------------------------------------------------------------------
  localparam logic [PHYS_AW-1:0] FLASH_LO = 28'h0000000;
  localparam logic [PHYS_AW-1:0] FLASH_HI = 28'h0077FFF;
  localparam logic [PHYS_AW-1:0] INTERNAL_HI = 28'h00FFFFF;
  localparam logic [PHYS_AW-1:0] RAM_LO = 28'h3FF7000;
  localparam logic [PHYS_AW-1:0] RAM_HI = 28'h3FFEFFF;
  localparam logic [PHYS_AW-1:0] RAM_MIR_LO = 28'hFFF7000;
  localparam logic [PHYS_AW-1:0] RAM_MIR_HI = 28'hFFFEFFF;
  localparam logic [PHYS_AW-1:0] FIXP_LO = 28'hFFFF000;
  localparam logic [PHYS_AW-1:0] RESET_VECTOR = 28'h0000000;

  // Offsets inside the regions
  localparam int RAM_OFS_W = 15;   // 32 KB
  localparam int PERI_OFS_W = 12;  // 4 KB
  localparam int PPW_OFS_W = 14;   // 16 KB
  localparam logic [1:0] PPW_TOP_QUARTER = 2'h3;
  localparam logic [PHYS_AW-1:0] PPW_SIZE = 28'h0004000;

  // ----------------------------------------------------------------------
  // Target encoding, one-hot
  // ----------------------------------------------------------------------
  typedef enum logic [5:0] {
    TGT_NONE  = 6'h01,
    TGT_FLASH = 6'h02,
    TGT_RAM   = 6'h04,
    TGT_PERI  = 6'h08,
    TGT_EXT   = 6'h10,
    TGT_FAULT = 6'h20
  } target_t;

  // Access size
  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0,
    SZ_HALF = 2'h1,
    SZ_WORD = 2'h2
  } acc_size_t;

  localparam logic [15:0] BYTE_REG_UPPER = 16'hFF00; // Undefined upper byte fill

  // Field widths used by the peripheral data path
  localparam int WORD_ALIGN_W = 2; // Offset bits ignored for word registers
  localparam int BYTE_LANE_W = 8; // Width of a byte-wide register
endpackage

// *** pkg/region_if.sv ***
// Interface carrying a physical address to the region classifier.
// Assumes both ends sit on the same clock.
`timescale 1ns/100ps
interface region_if;
  import addr_map_pkg::*;
  logic [PHYS_AW-1:0] phys;
  logic [PHYS_AW-1:0] ppw_base;
  logic fetch;
  target_t target;
  logic is_ram;
  logic is_peri;
  logic [RAM_OFS_W-1:0] ram_ofs;
  logic [PERI_OFS_W-1:0] peri_ofs;
  modport requester(output phys, output ppw_base, output fetch,
    input target, input is_ram, input is_peri, input ram_ofs, input peri_ofs);
  modport classifier(input phys, input ppw_base, input fetch,
    output target, output is_ram, output is_peri, output ram_ofs, output peri_ofs);
endinterface

// *** rtl/region_classify.sv ***
// Combinational region classifier for a 28-bit physical address.
// Assumes the caller registers the outcome.
`timescale 1ns/100ps
module region_classify
  import addr_map_pkg::*;
(
  region_if.classifier rif
);
  logic in_flash;
  logic in_ram;
  logic in_mir;
  logic in_fixp;
  logic in_ppw;
  logic ppw_top;
  logic [PHYS_AW-1:0] ppw_ofs;

  // Region hits
  always_comb begin
    ppw_ofs = rif.phys - rif.ppw_base;
    in_flash = (rif.phys <= FLASH_HI);
    in_ram = (rif.phys >= RAM_LO) && (rif.phys <= RAM_HI);
    in_mir = (rif.phys >= RAM_MIR_LO) && (rif.phys <= RAM_MIR_HI);
    in_fixp = (rif.phys >= FIXP_LO);
    in_ppw = (rif.phys >= rif.ppw_base) && (ppw_ofs < PPW_SIZE);
    ppw_top = in_ppw && (ppw_ofs[PPW_OFS_W-1:PERI_OFS_W] == PPW_TOP_QUARTER);
  end

  // Single target per access, priority flash, RAM, peripheral, external
  always_comb begin
    rif.is_ram = 1'b0;
    rif.is_peri = 1'b0;
    rif.ram_ofs = rif.phys[RAM_OFS_W-1:0] - RAM_LO[RAM_OFS_W-1:0];
    rif.peri_ofs = rif.phys[PERI_OFS_W-1:0];
    if (in_flash) begin
      rif.target = TGT_FLASH;
    end else if (in_ram || in_mir) begin
      rif.target = TGT_RAM;
      rif.is_ram = 1'b1;
    end else if (in_fixp || in_ppw) begin
      rif.is_peri = 1'b1;
      rif.target = rif.fetch ? TGT_FAULT : TGT_PERI;
    end else if (rif.phys <= INTERNAL_HI) begin
      rif.target = TGT_NONE;
    end else begin
      rif.target = TGT_EXT;
    end
    if (ppw_top) begin
      rif.peri_ofs = ppw_ofs[PERI_OFS_W-1:0];
    end
  end
endmodule

// *** tb/addr_map_checker.sv ***
// Port assertions for the address map decoder.
// Assumes one clock and a one-cycle registered answer.
`timescale 1ns/100ps
module addr_map_checker
  import addr_map_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [PHYS_AW-1:0] peripheral_window_base_select,
  input wire logic req_valid,
  input wire logic req_fetch,
  input wire logic req_write,
  input wire logic [1:0] req_size,
  input wire logic req_byte_reg,
  input wire logic [CPU_AW-1:0] req_base,
  input wire logic [CPU_AW-1:0] req_disp,
  input wire logic [15:0] req_wdata,
  input wire logic branch_load,
  input wire logic [CPU_AW-1:0] branch_target,
  input wire logic [CPU_AW-1:0] pc_ff,
  input wire logic [5:0] sel_ff,
  input wire logic [PHYS_AW-1:0] phys_addr_ff,
  input wire logic [RAM_OFS_W-1:0] ram_addr_ff,
  input wire logic [PERI_OFS_W-1:0] peri_addr_ff,
  input wire logic [15:0] peri_wdata_ff,
  input wire logic peri_write_ff,
  input wire logic fetch_fault_ff
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // Physical address and window hit of the current request
  logic [31:0] sum_w;
  logic [27:0] ph_w;
  logic [9:0] po_w;
  logic [25:0] bt_w;
  logic win_w;
  logic go_w;
  logic ram_w;
  assign sum_w = req_base + req_disp;
  assign ph_w = req_fetch ? {2'h0, sum_w[25:0]} : sum_w[27:0];
  assign po_w = ph_w[11:2];
  assign bt_w = branch_target[25:0];
  assign win_w = ph_w[27:14] == peripheral_window_base_select[27:14];
  assign go_w = req_valid && !req_fetch;
  assign ram_w = (ph_w >= RAM_LO && ph_w <= RAM_HI) || (ph_w >= RAM_MIR_LO && ph_w <= RAM_MIR_HI);
  AST_ONE_SEL: assert property ($onehot(sel_ff)) else $error("select not one-hot");
  AST_PHYS: assert property (req_valid |=> phys_addr_ff == $past(ph_w))
    else $error("physical address wrong");
  AST_FLASH: assert property (req_valid && ph_w <= FLASH_HI |=> sel_ff == 6'h02)
    else $error("flash not selected");
  AST_RAM: assert property (req_valid && ((ph_w >= RAM_LO && ph_w <= RAM_HI)
    || (ph_w >= RAM_MIR_LO && ph_w <= RAM_MIR_HI)) |=> sel_ff == 6'h04) else $error("ram miss");
  AST_FIXP: assert property (go_w && ph_w >= FIXP_LO |=> sel_ff == 6'h08
    && peri_addr_ff[11:2] == $past(po_w)) else $error("fixed area miss");
  AST_WIN: assert property (go_w && win_w && ph_w[13:12] == PPW_TOP_QUARTER
    |=> sel_ff == 6'h08 && peri_addr_ff[11:2] == $past(po_w)) else $error("alias miss");
  AST_FAULT: assert property (req_valid && req_fetch && win_w
    |=> fetch_fault_ff && sel_ff == 6'h20) else $error("fetch not refused");
  AST_WORD: assert property (req_valid && req_size == 2'h2
    |=> sel_ff != 6'h08 || peri_addr_ff[1:0] == 2'h0) else $error("word offset low bits");
  AST_BYTEW: assert property (go_w && req_write && req_byte_reg && req_size == 2'h1
    && ph_w >= FIXP_LO |=> peri_write_ff && peri_wdata_ff == ($past(req_wdata) & 16'h00FF))
    else $error("byte write data");
  AST_PC: assert property (branch_load |=> pc_ff == {6'h00, $past(bt_w)})
    else $error("pc top bits");
  AST_EXT: assert property (go_w && ph_w[27:24] == 4'h1 && !win_w |=> sel_ff == 6'h10)
    else $error("external miss");
  AST_RAMOFS: assert property (req_valid && ram_w
    |=> ram_addr_ff == $past(ph_w[14:0]) - 15'h7000) else $error("ram offset wrong");
endmodule
bind cpu_address_map_decoder addr_map_checker u_addr_map_checker (.*);

// *** tb/peri_bus_model.sv ***
// Register file on the internal peripheral bus.
// Assumes registered decoder outputs on sys_clk.
`timescale 1ns/100ps
module peri_bus_model (
  input wire logic sys_clk,
  input wire logic [5:0] sel_ff,
  input wire logic [11:0] peri_addr_ff,
  input wire logic [15:0] peri_wdata_ff,
  input wire logic peri_write_ff,
  output logic [15:0] peri_rdata
);
  logic [15:0] regs_ff [16];
  // Half-word store picked by offset bits 4..1
  always_ff @(posedge sys_clk) begin
    if (peri_write_ff) begin
      regs_ff[peri_addr_ff[4:1]] <= peri_wdata_ff;
    end
  end
  // Unselected bus shows inverted data, never a stale copy
  assign peri_rdata = sel_ff[3] ? regs_ff[peri_addr_ff[4:1]] : ~regs_ff[peri_addr_ff[4:1]];
endmodule

// *** tb/cpu_address_map_decoder_tb_top.sv ***
// Self-checking bench for the address map decoder.
// Assumes the bound checker and the peripheral model.
`timescale 1ns/100ps
module cpu_address_map_decoder_tb_top;
  import addr_map_pkg::*;
  logic sys_clk = 1'h0, sys_rst = 1'h1, prog_mode = 1'h0, req_valid = 1'h0, req_fetch = 1'h0;
  logic req_write = 1'h0, req_byte_reg = 1'h0, branch_load = 1'h0, vld_d = 1'h0;
  logic [1:0] req_size = 2'h1;
  logic [31:0] req_base = 32'h0, req_disp = 32'h0, branch_target = 32'h0, pc_ff;
  logic [15:0] req_wdata = 16'h0, peri_rdata, rdata_ff, peri_wdata_ff;
  logic [27:0] peripheral_window_base_select = 28'h0200000, phys_addr_ff;
  logic [5:0] sel_ff;
  logic [14:0] ram_addr_ff;
  logic [11:0] peri_addr_ff;
  logic boot_load_ff, peri_write_ff, fetch_fault_ff, req_ready;
  int err_total = 0, tests_run = 0;
  logic [33:0] exp_q[$];
  initial forever #4 sys_clk = ~sys_clk;
  cpu_address_map_decoder u_cpu_address_map_decoder (.*);
  peri_bus_model u_peri_bus_model (.*);
  task automatic chk(logic [33:0] g, logic [33:0] e);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_data(logic [31:0] g, logic [31:0] e);
    chk({2'h0, g}, {2'h0, e});
  endtask
  // Expected select and physical address, highest priority first
  function automatic logic [33:0] exp_of(logic [31:0] s, logic f);
    logic [27:0] p;
    p = f ? {2'h0, s[25:0]} : s[27:0];
    if (p <= FLASH_HI) return {6'h02, p};
    if ((p >= RAM_LO && p <= RAM_HI) || (p >= RAM_MIR_LO && p <= RAM_MIR_HI)) return {6'h04, p};
    if (p >= FIXP_LO || p[27:14] == peripheral_window_base_select[27:14])
      return {f ? 6'h20 : 6'h08, p};
    return {p <= INTERNAL_HI ? 6'h01 : 6'h10, p};
  endfunction
  // One request per falling edge, valid held across back-to-back calls
  task automatic req(logic [31:0] b, logic [31:0] d, logic f, logic w, logic [1:0] z, logic y);
    req_valid = 1'h1;
    req_base = b;
    req_disp = d;
    req_fetch = f;
    req_write = w;
    req_size = z;
    req_byte_reg = y;
    exp_q.push_back(exp_of(b + d, f));
    @(negedge sys_clk);
  endtask
  always @(posedge sys_clk) vld_d <= req_valid && !sys_rst;
  always @(negedge sys_clk) if (vld_d) chk({sel_ff, phys_addr_ff}, exp_q.pop_front());
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    err_total++;
    print_verdict;
  end
  initial begin
    void'($urandom(37));
    repeat (20) @(negedge sys_clk);
    sys_rst = 1'h0;
    chk_data(pc_ff, 32'h0);
    req(32'hFFFFFFFF, 32'h1, 0, 0, 2'h1, 0);
    req(32'h00077FFE, 32'h0, 0, 0, 2'h1, 0);
    req(32'h00078000, 32'h0, 0, 0, 2'h1, 0);
    req(32'h73FF7000, 32'h0, 0, 0, 2'h1, 0);
    req(32'h03FFEFFF, 32'h0, 0, 0, 2'h1, 0);
    req(32'hFFFF7000, 32'h0, 0, 0, 2'h1, 0);
    req(32'h03FFF000, 32'h0, 0, 0, 2'h1, 0);
    req(32'h03FFFFFF, 32'h2, 1, 0, 2'h1, 0);
    req(32'h02030F0, 32'h0, 1, 0, 2'h1, 0);
    req(32'hFFFFF016, 32'h0, 0, 0, 2'h2, 0);
    req(32'h03FF7ABC, 32'h0, 0, 0, 2'h1, 0);
    chk_data({17'h0, ram_addr_ff}, 32'h00000ABC);
    req(32'hEFFF7ABC, 32'h0, 0, 1, 2'h1, 0);
    chk_data({17'h0, ram_addr_ff}, 32'h00000ABC);
    $display("region test done");
    req_wdata = 16'hABCD;
    req(32'hFFFFF010, 32'h0, 0, 1, 2'h1, 1);
    req(32'h00203010, 32'h0, 0, 0, 2'h1, 0);
    req_valid = 1'h0;
    @(negedge sys_clk);
    chk_data(rdata_ff, 32'h00CD);
    req(32'hFFFFF010, 32'h0, 0, 0, 2'h1, 1);
    req_valid = 1'h0;
    @(negedge sys_clk);
    chk_data(rdata_ff, 32'hFFCD);
    $display("peripheral test done");
    repeat (200) req($urandom, $urandom, 1'($urandom), 0, 2'h1, 0);
    req_valid = 1'h0;
    branch_target = 32'hFFFFFFF0;
    branch_load = 1'h1;
    @(negedge sys_clk);
    branch_load = 1'h0;
    prog_mode = 1'h1;
    @(negedge sys_clk);
    chk_data(pc_ff, 32'h03FFFFF0);
    chk_data({31'h0, boot_load_ff}, 32'h1);
    sys_rst = 1'h1;
    repeat (2) @(negedge sys_clk);
    sys_rst = 1'h0;
    chk_data(pc_ff, 32'h0);
    chk_data({26'h0, sel_ff}, 32'h1);
    chk_data({31'h0, boot_load_ff}, 32'h0);
    chk_data({31'h0, req_ready}, 32'h1);
    $display("random and branch test done");
    print_verdict;
  end
endmodule
